/* test/ced_dispatch_assertions.sv */
module ced_dispatch_assertions (
    input logic        aclk,
    input logic        aresetn,
    input logic        exec_valid,
    input logic        brk_exec,
    input logic        abort_req,
    input logic        ext_irq,
    input logic        ret_exec,
    input logic [31:0] ret_flags,
    input logic [31:0] cur_ip,
    input logic [1:0]  gate_kind,
    input logic        disp_valid,
    input logic [7:0]  disp_vector,
    input logic [1:0]  disp_class,
    input logic        disp_push_flags,
    input logic [31:0] disp_saved_flags,
    input logic [31:0] disp_ret_ip,
    input logic        disp_ret_valid,
    input logic        disp_push_ec,
    input logic [31:0] flags_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // single clock domain, reset quiets every check
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // handler entry through an interrupt or trap gate
    sequence s_entry;
        disp_valid && disp_push_flags;
    endsequence
    a_trace_clear: assert property (s_entry |-> ##[0:1] !flags_word[8])
        else $error("trace flag kept on gate entry");
    a_intr_ie: assert property (s_entry ##0 $past(gate_kind) == 2'h2
        |-> ##[0:1] !flags_word[9]) else $error("enable kept on interrupt gate");
    a_trap_ie: assert property (s_entry ##0 $past(gate_kind) == 2'h3
        |=> flags_word[9] == $past(disp_saved_flags[9])) else $error("trap gate moved enable");
    // a return in a dispatch cycle loses to the dispatch
    a_ret_trace: assert property (ret_exec
        |=> disp_valid || flags_word[8] == $past(ret_flags[8])) else $error("trace not reloaded");
    a_no_ec: assert property (disp_valid && disp_class != 2'h2
        && (disp_vector == 8'h01 || disp_vector == 8'h06) |-> !disp_push_ec)
        else $error("error code on debug or opcode");
    a_abort_ret: assert property (disp_valid && disp_class == 2'h2 |-> !disp_ret_valid)
        else $error("abort reported a return point");
    a_brk_ip: assert property ($past(brk_exec) && disp_valid && disp_vector == 8'h03
        |-> disp_class == 2'h1 && disp_ret_ip == $past(cur_ip) + 32'h1)
        else $error("breakpoint return point wrong");
    a_prefetch_ud: assert property (!exec_valid && !abort_req && !ext_irq
        |=> !(disp_valid && disp_vector == 8'h06)) else $error("opcode fault on prefetch");
    a_div_fault: assert property (disp_valid && disp_vector == 8'h00
        && $past(exec_valid) && !$past(ext_irq) && !$past(abort_req)
        |-> disp_class == 2'h0 && disp_ret_ip == $past(cur_ip)) else $error("divide fault wrong");
endmodule

bind ced_dispatch ced_dispatch_assertions u_chk (.*);

/* test/ced_dispatch_tb_top.sv */
`include "ced_regs.vh"
module ced_dispatch_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, gate_kind, gate_dpl, disp_class, disp_stack_dpl, rsp;
    logic [31:0] s_axi_wdata, s_axi_rdata, ret_flags, cur_ip, next_ip, xfer_ip, rd;
    logic [31:0] disp_saved_flags, disp_ret_ip, disp_error_code, flags_word;
    logic [15:0] cur_cs, xfer_cs, gate_selector, disp_tss_selector, disp_ret_cs;
    logic [12:0] ec_index_in;
    logic [7:0] ext_vector, disp_vector;
    logic exec_valid, div_zero, dbg_fault, dbg_trap, brk_exec, ovf_exec, bound_viol;
    logic opcode_bad, operand_bad, lock_bad, abort_req, ext_irq, ret_exec, xfer_taken;
    logic ec_valid_in, ec_ext_in, ec_idt_in, ec_ti_in, disp_valid, disp_task_switch;
    logic disp_push_flags, disp_ret_valid, disp_push_ec;
    wire [12:0] ev;
    int errors, total_checks, cyc;
    assign {ret_exec, ext_irq, abort_req, lock_bad, operand_bad, opcode_bad, bound_viol,
        ovf_exec, brk_exec, dbg_trap, dbg_fault, div_zero, exec_valid} = ev;
    ced_dispatch dut (.*);
    ced_exec_model u_exec (.aclk(aclk), .ev(ev));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // cycle ceiling against a hung handshake
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // each channel released at the edge where it is taken
    task axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && s_axi_awready !== 1'b1)
            || (s_axi_wvalid && s_axi_wready !== 1'b1));
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    // condition taken at the second edge, dispatch seen just after it
    task fire(input int code, input logic ex);
        u_exec.issue(code, ex);
        #1;
    endtask
    task t_regs;
        axr(`CED_ADDR_CTRL);
        chk(rd[0], 1'b1);
        axr(`CED_ADDR_FLAGS);
        chk(rd, `CED_FLAGS_RST);
        axw(`CED_ADDR_PRIV, 32'h0);
        chk(rsp, `CED_RESP_OKAY);
        axw(`CED_ADDR_STATUS, 32'h0);
        chk(rsp, `CED_RESP_SLVERR);
        $display("registers done");
    endtask
    task t_intr;
        axw(`CED_ADDR_FLAGS, 32'h302);
        gate_kind <= `CED_GATE_INTR;
        fire(10, 1'b0);
        chk(disp_vector, 8'h21);
        chk(disp_saved_flags, 32'h302);
        chk(disp_push_flags, 1'b1);
        @(posedge aclk);
        #1;
        chk(flags_word[9:8], 2'b00);
        ret_flags <= 32'h302;
        fire(11, 1'b0);
        chk(flags_word[9:8], 2'b11);
        axw(`CED_ADDR_PRIV, 32'h3);
        ret_flags <= 32'h2;
        fire(11, 1'b0);
        chk(flags_word[9:8], 2'b10);
        axw(`CED_ADDR_PRIV, 32'h0);
        $display("interrupt gate done");
    endtask
    task t_trap;
        axw(`CED_ADDR_FLAGS, 32'h302);
        {gate_kind, cur_ip, next_ip} <= {`CED_GATE_TRAP, 32'h100, 32'h102};
        fire(3, 1'b1);
        chk(disp_class, `CED_CLS_TRAP);
        chk(disp_ret_ip, 32'h101);
        @(posedge aclk);
        #1;
        chk(flags_word[9:8], 2'b10);
        fire(2, 1'b0);
        chk(disp_ret_ip, 32'h102);
        xfer_taken <= 1'b1;
        fire(2, 1'b0);
        chk({disp_ret_cs, disp_ret_ip[15:0]}, 32'h00100500);
        xfer_taken <= 1'b0;
        $display("trap gate done");
    endtask
    task t_faults;
        int codes[6] = '{0, 1, 5, 6, 7, 8};
        int vecs[6] = '{0, 1, 5, 6, 6, 6};
        fire(6, 1'b0);
        chk(disp_valid, 1'b0);
        for (int i = 0; i < 6; i++) begin
            fire(codes[i], 1'b1);
            chk(disp_vector, vecs[i]);
            chk({disp_class, disp_ret_ip}, {`CED_CLS_FAULT, 32'h100});
        end
        fire(4, 1'b1);
        chk(disp_valid, 1'b0);
        axw(`CED_ADDR_FLAGS, 32'h802);
        fire(4, 1'b1);
        chk({disp_vector, disp_class}, {`CED_VEC_OVF, `CED_CLS_TRAP});
        chk(disp_ret_ip, 32'h102);
        $display("fault table done");
    endtask
    task t_prot;
        {gate_kind, gate_dpl} <= {`CED_GATE_INTR, 2'h3};
        fire(10, 1'b0);
        chk({disp_vector, disp_task_switch}, {`CED_VEC_GP, 1'b0});
        chk(disp_error_code, 32'h10b);
        gate_dpl <= 2'h0;
        $display("privilege check done");
    endtask
    task t_task;
        {gate_kind, gate_selector} <= {`CED_GATE_TASK, 16'h34};
        {ec_valid_in, ec_ti_in, ec_index_in} <= {2'b11, 13'h5};
        gate_dpl <= 2'h2;
        fire(9, 1'b0);
        chk({disp_task_switch, disp_tss_selector}, 17'h10030);
        chk({disp_push_flags, disp_stack_dpl}, 3'b010);
        chk({disp_class, disp_ret_valid}, {`CED_CLS_ABORT, 1'b0});
        chk(disp_push_ec, 1'b1);
        chk(disp_error_code, 32'h2c);
        {ec_idt_in, ec_ext_in} <= 2'b11;
        fire(9, 1'b0);
        chk(disp_error_code, 32'h2b);
        axr(`CED_ADDR_STATUS);
        chk(rd, 32'h00020e21);
        axw(`CED_ADDR_CTRL, 32'h0);
        fire(9, 1'b0);
        chk(disp_valid, 1'b0);
        axw(`CED_ADDR_CTRL, 32'h1);
        $display("task gate done");
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ret_flags, cur_ip, next_ip} = '0;
        {gate_kind, gate_dpl, gate_selector, ec_index_in, xfer_taken} = '0;
        {ec_valid_in, ec_ext_in, ec_idt_in, ec_ti_in} = '0;
        {s_axi_wstrb, cur_cs, xfer_cs} = {4'hf, 16'h8, 16'h10};
        {xfer_ip, ext_vector} = {32'h500, 8'h21};
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_intr();
        t_trap();
        t_faults();
        t_prot();
        t_task();
        report_and_stop();
    end
endmodule

/* test/ced_exec_model.sv */
module ced_exec_model (
    input  logic        aclk,
    output logic [12:0] ev
);
    timeunit 1ns;
    timeprecision 1ps;
    // bit 0 is the execute qualifier, bits 12:1 one condition each
    initial ev = '0;
    // one condition for one cycle; qualifier low models a prefetch only
    task issue(input int code, input logic ex);
        @(posedge aclk);
        ev <= {12'h1 << code, ex};
        @(posedge aclk);
        ev <= '0;
    endtask
endmodule

/* verilog/ced_dispatch.v */
`include "ced_regs.vh"
module ced_dispatch (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // condition reports from the execution unit, one-cycle pulses
    input  wire        exec_valid,
    input  wire        div_zero,
    input  wire        dbg_fault,
    input  wire        dbg_trap,
    input  wire        brk_exec,
    input  wire        ovf_exec,
    input  wire        bound_viol,
    input  wire        opcode_bad,
    input  wire        operand_bad,
    input  wire        lock_bad,
    input  wire        abort_req,
    input  wire        ext_irq,
    input  wire [7:0]  ext_vector,
    input  wire        ret_exec,
    input  wire [31:0] ret_flags,
    input  wire        xfer_taken,
    input  wire [31:0] cur_ip,
    input  wire [31:0] next_ip,
    input  wire [31:0] xfer_ip,
    input  wire [15:0] cur_cs,
    input  wire [15:0] xfer_cs,
    // descriptor lookup result for the vector being dispatched
    input  wire [1:0]  gate_kind,
    input  wire [1:0]  gate_dpl,
    input  wire [15:0] gate_selector,
    input  wire        ec_valid_in,
    input  wire        ec_ext_in,
    input  wire        ec_idt_in,
    input  wire        ec_ti_in,
    input  wire [12:0] ec_index_in,
    // dispatch outputs
    output reg         disp_valid,
    output reg  [7:0]  disp_vector,
    output reg  [1:0]  disp_class,
    output reg         disp_task_switch,
    output reg  [15:0] disp_tss_selector,
    output reg         disp_push_flags,
    output reg  [31:0] disp_saved_flags,
    output reg  [15:0] disp_ret_cs,
    output reg  [31:0] disp_ret_ip,
    output reg         disp_ret_valid,
    output reg         disp_push_ec,
    output reg  [31:0] disp_error_code,
    output reg  [1:0]  disp_stack_dpl,
    output reg  [31:0] flags_word
);
    // state kept by the dispatcher itself
    // flags_reg is the only architectural state here; everything
    // else is either a register-bus copy or a dispatch record
    // the record outputs hold until the next dispatch, so the
    // execution unit may read them any time after disp_valid
    // disp_valid itself stands for exactly one cycle
    // priv_reg packs current level in [1:0], io level in [3:2]
    // enable gates dispatch only, not the handler return path
    reg  [31:0] flags_reg;      // live flags word
    reg  [3:0]  priv_reg;       // current and io privilege
    reg         enable;         // dispatch enable from ctrl
    reg  [7:0]  last_vector;    // status shows last dispatched vector
    reg  [1:0]  last_class;
    reg  [7:0]  disp_count;     // dispatch counter for status
    wire [1:0]  cur_pl = priv_reg[`CED_PRIV_CUR_LO +: 2];
    wire [1:0]  io_pl  = priv_reg[`CED_PRIV_IO_LO +: 2];

    // register bus write side
    // address and data may arrive in either order; each is parked
    // in its own holding register until its partner shows up
    // ready drops while parked or while a response is pending,
    // so one write at most is ever in flight
    // the cost is two idle cycles between back-to-back writes,
    // which is harmless for a control port like this one
    // write channel: take address and data in either order
    reg        aw_held;
    reg        w_held;
    reg [3:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire       wr_go = aw_held && w_held;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    // condition classification
    // at most one event is taken per cycle; lower-priority reports
    // raised in the same cycle are dropped, and the execution unit
    // is expected to raise them again after the handler returns
    // debug traps from the previous instruction outrank everything
    // but an abort, then code breakpoints, then external events
    // execute-time conditions count only with exec_valid high,
    // which keeps a prefetched invalid opcode from faulting early
    // ev_ext marks events from outside the running program; it
    // feeds the error code and steers the return pointer
    // condition classification, priority by fault ordering
    reg        ev;
    reg [7:0]  ev_vec;
    reg [1:0]  ev_cls;
    reg        ev_ec;
    reg        ev_ext;
    always @* begin
        ev     = 1'b0;
        ev_vec = `CED_VEC_DIV;
        ev_cls = `CED_CLS_FAULT;
        ev_ec  = 1'b0;
        ev_ext = 1'b0;
        if (abort_req) begin
            // abort: vector from reporter, no restart point
            ev     = 1'b1;
            ev_vec = ext_vector;
            ev_cls = `CED_CLS_ABORT;
            ev_ec  = ec_valid_in;
        end else if (dbg_trap) begin
            ev     = 1'b1;
            ev_vec = `CED_VEC_DBG;
            ev_cls = `CED_CLS_TRAP;
        end else if (dbg_fault) begin
            ev     = 1'b1;
            ev_vec = `CED_VEC_DBG;
            ev_cls = `CED_CLS_FAULT;
        end else if (ext_irq) begin
            // external event, trap-like return to next
            ev     = 1'b1;
            ev_vec = ext_vector;
            ev_cls = `CED_CLS_TRAP;
            ev_ext = 1'b1;
            ev_ec  = ec_valid_in;
        end else if (exec_valid) begin
            // execute-time checks only; prefetch never reaches here
            if (opcode_bad || operand_bad || lock_bad) begin
                ev     = 1'b1;
                ev_vec = `CED_VEC_UD;
                ev_cls = `CED_CLS_FAULT;
            end else if (div_zero) begin
                ev     = 1'b1;
                ev_vec = `CED_VEC_DIV;
                ev_cls = `CED_CLS_FAULT;
            end else if (bound_viol) begin
                ev     = 1'b1;
                ev_vec = `CED_VEC_BND;
                ev_cls = `CED_CLS_FAULT;
            end else if (brk_exec) begin
                ev     = 1'b1;
                ev_vec = `CED_VEC_BRK;
                ev_cls = `CED_CLS_TRAP;
            end else if (ovf_exec && flags_reg[`CED_FLAG_OVF]) begin
                ev     = 1'b1;
                ev_vec = `CED_VEC_OVF;
                ev_cls = `CED_CLS_TRAP;
            end
        end
    end

    // privilege check
    // only interrupt and trap gates run a handler in the current
    // task, so only they are checked against the current level;
    // a task gate switches context instead and is never refused
    // a larger level number means less privilege
    // privilege check: handler less privileged than current
    wire gate_is_proc = (gate_kind == `CED_GATE_INTR) || (gate_kind == `CED_GATE_TRAP);
    wire priv_fail    = gate_is_proc && (gate_dpl > cur_pl);
    wire take         = ev && enable;

    // error code assembly
    // bit 0 external event, bit 1 vector-table reference,
    // bit 2 table select, bits 15:3 selector index
    // table select is meaningless once the vector-table bit is
    // set, so it is forced low then to keep the code canonical
    // the upper half always reads zero to keep stack alignment
    // error code: ext, idt, ti, index; upper half reserved zero
    wire [31:0] ec_word = {16'h0000, ec_index_in, ec_ti_in & ~ec_idt_in,
                           ec_idt_in, ec_ext_in | ev_ext};

    // gp error code names the faulting gate in the vector table
    wire [31:0] gp_code = {16'h0000, 5'h00, ev_vec, 1'b0, 1'b1, ev_ext};

    // return pointer selection
    // faults point back at the instruction so it can restart
    // traps point past it, or to where a transfer went
    // the breakpoint byte is one long, so its trap resumes at
    // cur_ip plus one whatever next_ip reports, when xfer_taken is low
    // aborts keep a pointer, but disp_ret_valid marks it unusable
    // return pointer chosen by class
    reg [31:0] ret_ip;
    reg [15:0] ret_cs;
    always @* begin
        ret_ip = cur_ip;
        ret_cs = cur_cs;
        if (ev_cls == `CED_CLS_TRAP) begin
            if (xfer_taken) begin
                ret_ip = xfer_ip;
                ret_cs = xfer_cs;
            end else if (ev_vec == `CED_VEC_BRK && !ev_ext) begin
                ret_ip = cur_ip + `CED_BRK_LEN;
            end else begin
                ret_ip = next_ip;
            end
        end
    end

    // main sequential process
    // one clock, synchronous reset; every register runs each edge
    // priority inside one cycle: dispatch, then handler return,
    // then a flags write from the register bus
    // a flags write that loses still gets an okay response; the
    // bus side cannot tell, which keeps the response path simple
    // a handler return in a dispatch cycle is lost as well, though
    // the new handler's entry clears only trace, and enable for an interrupt gate
    // dispatch register, flags update and register file
    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg         <= `CED_FLAGS_RST;
            priv_reg          <= 4'h0;
            enable            <= 1'b1;
            last_vector       <= 8'h00;
            last_class        <= 2'h0;
            disp_count        <= 8'h00;
            disp_valid        <= 1'b0;
            disp_vector       <= 8'h00;
            disp_class        <= 2'h0;
            disp_task_switch  <= 1'b0;
            disp_tss_selector <= 16'h0000;
            disp_push_flags   <= 1'b0;
            disp_saved_flags  <= 32'h00000000;
            disp_ret_cs       <= 16'h0000;
            disp_ret_ip       <= 32'h00000000;
            disp_ret_valid    <= 1'b0;
            disp_push_ec      <= 1'b0;
            disp_error_code   <= 32'h00000000;
            disp_stack_dpl    <= 2'h0;
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= 4'h0;
            w_data            <= 32'h00000000;
            w_strb            <= 4'h0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `CED_RESP_OKAY;
            s_axi_rvalid      <= 1'b0;
            s_axi_rresp       <= `CED_RESP_OKAY;
            s_axi_rdata       <= 32'h00000000;
        end else begin
            disp_valid <= take;
            if (take) begin
                disp_count      <= disp_count + 8'h01;
                disp_ret_cs     <= ret_cs;
                disp_ret_ip     <= ret_ip;
                disp_ret_valid  <= (ev_cls != `CED_CLS_ABORT);
                disp_saved_flags <= flags_reg; // saved before clearing
                disp_stack_dpl  <= gate_dpl;
                // a refused gate becomes a general-protection fault;
                // flags stay as they were and no task switch starts
                // so the faulting handler sees the original state
                if (priv_fail) begin
                    // dispatch general protection instead
                    disp_vector      <= `CED_VEC_GP;
                    disp_class       <= `CED_CLS_FAULT;
                    disp_task_switch <= 1'b0;
                    disp_push_flags  <= 1'b0;
                    disp_push_ec     <= 1'b1;
                    disp_error_code  <= gp_code;
                    last_vector      <= `CED_VEC_GP;
                    last_class       <= `CED_CLS_FAULT;
                end else begin
                    disp_vector      <= ev_vec;
                    disp_class       <= ev_cls;
                    last_vector      <= ev_vec;
                    last_class       <= ev_cls;
                    disp_push_ec     <= ev_ec;
                    disp_error_code  <= ev_ec ? ec_word : 32'h00000000;
                    disp_task_switch <= (gate_kind == `CED_GATE_TASK);
                    disp_tss_selector <= {gate_selector[15:3], 1'b0,
                                          gate_selector[1:0]};
                    disp_push_flags  <= gate_is_proc;
                    // flags are saved before they are cleared: the
                    // record takes flags_reg at this edge, while the
                    // cleared bits land in flags_reg at the same edge
                    if (gate_is_proc) begin
                        flags_reg[`CED_FLAG_TRACE] <= 1'b0;
                        if (gate_kind == `CED_GATE_INTR)
                            flags_reg[`CED_FLAG_IE] <= 1'b0;
                        // trap gate keeps interrupt enable
                    end
                end
            end else if (ret_exec) begin
                // handler return restores trace and overflow, and maybe enable
                flags_reg[`CED_FLAG_TRACE] <= ret_flags[`CED_FLAG_TRACE];
                flags_reg[`CED_FLAG_OVF]   <= ret_flags[`CED_FLAG_OVF];
                if (cur_pl <= io_pl)
                    flags_reg[`CED_FLAG_IE] <= ret_flags[`CED_FLAG_IE];
            end else if (wr_go && aw_addr == `CED_ADDR_FLAGS) begin
                flags_reg <= (flags_reg & ~wmask) | (w_data & wmask);
            end
            // register bus write acceptance
            // awvalid and wvalid are parked independently; the
            // response is raised the cycle after both are parked,
            // and the holding registers clear at that same edge
            // axi write
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `CED_RESP_OKAY;
                case (aw_addr)
                    `CED_ADDR_CTRL:  if (w_strb[0]) enable <= w_data[0];
                    `CED_ADDR_PRIV:  if (w_strb[0]) priv_reg <= w_data[3:0];
                    `CED_ADDR_FLAGS: ;
                    default:         s_axi_bresp <= `CED_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // register bus read
            // data is registered, so rvalid comes one cycle after
            // arvalid is taken; arready stays low until rready
            // drains the response, allowing one read in flight
            // axi read
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `CED_RESP_OKAY;
                case (s_axi_araddr)
                    `CED_ADDR_CTRL:   s_axi_rdata <= {31'h0, enable};
                    `CED_ADDR_FLAGS:  s_axi_rdata <= flags_reg;
                    `CED_ADDR_PRIV:   s_axi_rdata <= {28'h0, priv_reg};
                    `CED_ADDR_STATUS: s_axi_rdata <= {14'h0, last_class, disp_count,
                                                      last_vector};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `CED_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // live flags word
    // copied straight out so the core sees the cleared trace and
    // enable bits on the same edge that disp_valid rises
    // live flags visible to the core
    always @* begin
        flags_word = flags_reg;
    end
endmodule

/* verilog/ced_regs.vh */
`ifndef CED_REGS_VH
`define CED_REGS_VH
// axi register byte offsets
`define CED_ADDR_CTRL      4'h0
`define CED_ADDR_FLAGS     4'h4
`define CED_ADDR_PRIV      4'h8
`define CED_ADDR_STATUS    4'hc
// flags word bit positions
`define CED_FLAG_TRACE     8
`define CED_FLAG_IE        9
`define CED_FLAG_OVF       11
// privilege field positions in priv register
`define CED_PRIV_CUR_LO    0
`define CED_PRIV_IO_LO     2
// gate kinds
`define CED_GATE_TASK      2'h1
`define CED_GATE_INTR      2'h2
`define CED_GATE_TRAP      2'h3
// exception classes
`define CED_CLS_FAULT      2'h0
`define CED_CLS_TRAP       2'h1
`define CED_CLS_ABORT      2'h2
// vectors
`define CED_VEC_DIV        8'h00
`define CED_VEC_DBG        8'h01
`define CED_VEC_BRK        8'h03
`define CED_VEC_OVF        8'h04
`define CED_VEC_BND        8'h05
`define CED_VEC_UD         8'h06
`define CED_VEC_GP         8'h0d
// error code bits
`define CED_EC_EXT         0
`define CED_EC_IDT         1
`define CED_EC_TI          2
// breakpoint instruction length
`define CED_BRK_LEN        32'h00000001
// axi responses
`define CED_RESP_OKAY      2'h0
`define CED_RESP_SLVERR    2'h2
// reset value of flags word, reserved bit 1 set
`define CED_FLAGS_RST      32'h00000002
`endif
